// ### hdl/bdms_top.sv
// Banked data memory, status register and cycle clock divider of the core.
// Assumes all inputs synchronous to CORE_CLK_I; APB master per the protocol.
//
// Decided for this implementation: register access over APB.

`timescale 1ns/1ps

module bdms_top
	import bdms_pkg::*;
#(
	parameter logic [7:0] GPR1_LAST = BDMS_GPR1_LAST_DFLT
)
(
	input wire logic CORE_CLK_I,
	input wire logic SYS_RST_I,
	input wire logic MCLR_N_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [11:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	input wire logic [3:0] PSTRB_I,
	output logic [31:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	input wire logic ALU_VALID_I,
	input wire bdms_alu_req_t ALU_REQ_I,
	output logic ALU_READY_O,
	output logic ALU_DONE_O,
	output logic [7:0] ALU_RESULT_O,
	input wire logic WDT_TIMEOUT_I,
	input wire logic SLEEP_I,
	input wire logic WDT_CLEAR_I,
	input wire logic OSC_IN_I,
	input wire logic RC_MODE_I,
	output logic CYCLE_CLK_O,
	output logic [7:0] STATUS_O,
	output logic IRQ_O
);

	// ----------------------------------------------------------------
	// Parameter check
	// ----------------------------------------------------------------
	if (GPR1_LAST < BDMS_GPR1_NONE)
	begin : g_bad_gpr1
		$error("GPR1_LAST below bank 1 general purpose start");
	end

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic rst;
	logic [7:0] mem [256];
	logic [7:0] status_r;
	logic [7:0] status_nxt;
	logic [7:0] indirect_pointer;
	logic ready_r;
	logic [31:0] prdata_r;
	logic pslverr_r;
	logic [8:0] idx;
	logic idx_bad;
	logic in_file;
	logic [7:0] pa_raw;
	logic [7:0] pa;
	logic pa_ok;
	logic [7:0] pa_val;
	logic apb_done;
	logic apb_wr;
	logic [7:0] ca_raw;
	logic [7:0] ca;
	logic ca_ok;
	logic [7:0] b_val;
	logic alu_acc;
	logic [7:0] a_opnd;
	logic cin;
	logic [8:0] sum;
	logic [4:0] nib;
	logic [7:0] res;
	logic aff_z;
	logic aff_cdc;
	logic [2:0] irq_stat_r;
	logic [2:0] irq_mask_r;
	logic [2:0] irq_set;
	logic alu_done_r;
	logic [7:0] alu_result_r;
	logic osc_prev_r;
	logic [BDMS_DIV_W-1:0] div_r;

	// ----------------------------------------------------------------
	// Address helpers
	// ----------------------------------------------------------------
	// Fold the bank 1 alias of a shared register onto its bank 0 copy
	function automatic logic [7:0] canon(input logic [7:0] a);
		logic [7:0] lo;
		lo = {1'b0, a[6:0]};
		if (lo == BDMS_PROG_COUNTER_LOW_OFS || lo == BDMS_ALU_RESET_FLAGS_OFS ||
			lo == BDMS_INDIRECT_POINTER_OFS || lo == BDMS_PROG_COUNTER_HIGH_LATCH_OFS ||
			lo == BDMS_INTERRUPT_CONTROL_OFS)
			canon = lo;
		else
			canon = a;
	endfunction

	// True where a physical location sits behind a canonical address
	function automatic logic implemented(input logic [7:0] a);
		implemented = (a == BDMS_TIMER0_COUNT_OFS) || (a == BDMS_PROG_COUNTER_LOW_OFS) ||
			(a == BDMS_ALU_RESET_FLAGS_OFS) || (a == BDMS_INDIRECT_POINTER_OFS) ||
			(a == BDMS_PORT_A_PINS_OFS) || (a == BDMS_PORT_B_PINS_OFS) ||
			(a == BDMS_PROG_COUNTER_HIGH_LATCH_OFS) || (a == BDMS_INTERRUPT_CONTROL_OFS) ||
			(a == BDMS_PERIPHERAL_INT_FLAGS_OFS) || (a == BDMS_COMPARATOR_CONTROL_OFS) ||
			(a == BDMS_CORE_OPTIONS_OFS) || (a == BDMS_PORT_A_DIRECTION_OFS) ||
			(a == BDMS_PORT_B_DIRECTION_OFS) || (a == BDMS_PERIPHERAL_INT_ENABLES_OFS) ||
			(a == BDMS_POWER_CONTROL_OFS) || (a == BDMS_VOLTAGE_REF_CONTROL_OFS) ||
			(a >= BDMS_GPR0_FIRST && a <= BDMS_GPR0_LAST) ||
			(a >= BDMS_GPR1_FIRST && a <= GPR1_LAST);
	endfunction

	// ----------------------------------------------------------------
	// Reset
	// ----------------------------------------------------------------
	// Master clear pin is treated as a synchronous level like the rest
	assign rst = SYS_RST_I | ~MCLR_N_I;

	// ----------------------------------------------------------------
	// Address resolution for both access paths
	// ----------------------------------------------------------------
	// Pointer register lives in the array; the port itself has no cell
	assign indirect_pointer = mem[BDMS_INDIRECT_POINTER_OFS];

	assign idx = PADDR_I[10:2];
	assign idx_bad = PADDR_I[11] || (idx > BDMS_IRQ_MASK_IDX);
	assign in_file = !PADDR_I[11] && !idx[8];
	assign pa_raw = (idx[6:0] == 7'h00) ? indirect_pointer : idx[7:0];
	assign pa = canon(pa_raw);
	// A pointer aimed back at the port itself reaches nothing
	assign pa_ok = in_file && (pa_raw[6:0] != 7'h00) && implemented(pa);
	assign pa_val = !pa_ok ? 8'h00 : (pa == BDMS_ALU_RESET_FLAGS_OFS) ? status_r : mem[pa];

	// Core direct addressing uses only the lower bank bit; upper bits are kept clear by software
	assign ca_raw = (ALU_REQ_I.addr == 7'h00) ? indirect_pointer : {status_r[BDMS_ST_RP0], ALU_REQ_I.addr};
	assign ca = canon(ca_raw);
	assign ca_ok = (ca_raw[6:0] != 7'h00) && implemented(ca);
	assign b_val = !ca_ok ? 8'h00 : (ca == BDMS_ALU_RESET_FLAGS_OFS) ? status_r : mem[ca];

	// ----------------------------------------------------------------
	// APB handshake
	// ----------------------------------------------------------------
	// One wait state: data is registered on the same edge that raises pready
	assign apb_done = PSEL_I && PENABLE_I && ready_r;
	assign apb_wr = apb_done && PWRITE_I && PSTRB_I[0];
	// An APB write completing this edge holds off the core for one cycle
	assign ALU_READY_O = !(apb_done && PWRITE_I);
	assign alu_acc = ALU_VALID_I && ALU_READY_O;
	assign PREADY_O = ready_r;
	assign PRDATA_O = prdata_r;
	assign PSLVERR_O = pslverr_r;

	// Ready flag, raised after one access cycle, dropped after completion
	always_ff @(posedge CORE_CLK_I)
	begin
		if (rst)
			ready_r <= 1'b0;
		else
			ready_r <= PSEL_I && PENABLE_I && !ready_r;
	end

	// Read data and error are captured in the first access cycle
	always_ff @(posedge CORE_CLK_I)
	begin
		if (rst)
		begin
			prdata_r <= 32'h0000_0000;
			pslverr_r <= 1'b0;
		end
		else if (PSEL_I && PENABLE_I && !ready_r)
		begin
			pslverr_r <= idx_bad;
			if (idx_bad)
				prdata_r <= 32'h0000_0000;
			else if (idx == BDMS_IRQ_STAT_IDX)
				prdata_r <= {29'h0000_0000, irq_stat_r};
			else if (idx == BDMS_IRQ_MASK_IDX)
				prdata_r <= {29'h0000_0000, irq_mask_r};
			else
				prdata_r <= {24'h00_0000, pa_val};
		end
		else
		begin
			prdata_r <= 32'h0000_0000;
			pslverr_r <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Arithmetic and logic unit
	// ----------------------------------------------------------------
	// Subtraction is file minus accumulator done as an add of the complement,
	// so carry and nibble carry come out as inverted borrows
	assign a_opnd = (ALU_REQ_I.op == BDMS_OP_SUB) ? ~ALU_REQ_I.acc : ALU_REQ_I.acc;
	assign cin = (ALU_REQ_I.op == BDMS_OP_SUB);
	assign sum = {1'b0, b_val} + {1'b0, a_opnd} + {8'h00, cin};
	assign nib = {1'b0, b_val[3:0]} + {1'b0, a_opnd[3:0]} + {4'h0, cin};

	// Result and which flags the operation owns
	always_comb
	begin
		res = ALU_REQ_I.acc;
		aff_z = 1'b0;
		aff_cdc = 1'b0;
		case (ALU_REQ_I.op)
			BDMS_OP_MOVE:
				res = ALU_REQ_I.acc;
			BDMS_OP_ADD, BDMS_OP_SUB:
			begin
				res = sum[7:0];
				aff_z = 1'b1;
				aff_cdc = 1'b1;
			end
			BDMS_OP_AND:
			begin
				res = b_val & ALU_REQ_I.acc;
				aff_z = 1'b1;
			end
			BDMS_OP_OR:
			begin
				res = b_val | ALU_REQ_I.acc;
				aff_z = 1'b1;
			end
			BDMS_OP_XOR:
			begin
				res = b_val ^ ALU_REQ_I.acc;
				aff_z = 1'b1;
			end
			BDMS_OP_CLR:
			begin
				res = 8'h00;
				aff_z = 1'b1;
			end
			BDMS_OP_SWAP:
				res = {b_val[3:0], b_val[7:4]};
			BDMS_OP_BCLR:
				res = b_val & ~(8'h01 << ALU_REQ_I.bit_sel);
			BDMS_OP_BSET:
				res = b_val | (8'h01 << ALU_REQ_I.bit_sel);
			default:
				res = ALU_REQ_I.acc;
		endcase
	end

	// ----------------------------------------------------------------
	// Status register
	// ----------------------------------------------------------------
	// Writes reach the bank and flag bits only; the two reset cause bits
	// follow device events alone, and owned flags take the result
	always_comb
	begin
		status_nxt = status_r;
		if (apb_wr && pa_ok && pa == BDMS_ALU_RESET_FLAGS_OFS)
			status_nxt = {PWDATA_I[7:5], status_r[4:3], PWDATA_I[2:0]};
		if (alu_acc)
		begin
			if (ALU_REQ_I.dest_file && ca_ok && ca == BDMS_ALU_RESET_FLAGS_OFS)
				status_nxt = {res[7:5], status_r[4:3], (aff_z || aff_cdc) ? status_r[2:0] : res[2:0]};
			if (aff_z)
				status_nxt[BDMS_ST_Z] = (res == 8'h00);
			if (aff_cdc)
			begin
				status_nxt[BDMS_ST_C] = sum[8];
				status_nxt[BDMS_ST_DC] = nib[4];
			end
		end
		if (WDT_CLEAR_I)
		begin
			status_nxt[BDMS_ST_WDOG] = 1'b1;
			status_nxt[BDMS_ST_SLEEP] = 1'b1;
		end
		if (WDT_TIMEOUT_I)
			status_nxt[BDMS_ST_WDOG] = 1'b0;
		if (SLEEP_I)
			status_nxt[BDMS_ST_SLEEP] = 1'b0;
	end

	always_ff @(posedge CORE_CLK_I)
	begin
		if (rst)
			status_r <= BDMS_STATUS_RST;
		else
			status_r <= status_nxt;
	end

	assign STATUS_O = status_r;

	// ----------------------------------------------------------------
	// Data memory array
	// ----------------------------------------------------------------
	// Contents are not reset, as in real static memory; status is kept apart
	always_ff @(posedge CORE_CLK_I)
	begin
		if (apb_wr && pa_ok && pa != BDMS_ALU_RESET_FLAGS_OFS)
			mem[pa] <= PWDATA_I[7:0];
		else if (alu_acc && ALU_REQ_I.dest_file && ca_ok && ca != BDMS_ALU_RESET_FLAGS_OFS)
			mem[ca] <= res;
	end

	// ----------------------------------------------------------------
	// Core answer
	// ----------------------------------------------------------------
	always_ff @(posedge CORE_CLK_I)
	begin
		if (rst)
		begin
			alu_done_r <= 1'b0;
			alu_result_r <= 8'h00;
		end
		else
		begin
			alu_done_r <= alu_acc;
			if (alu_acc)
				alu_result_r <= res;
		end
	end

	assign ALU_DONE_O = alu_done_r;
	assign ALU_RESULT_O = alu_result_r;

	// ----------------------------------------------------------------
	// Interrupt status and mask
	// ----------------------------------------------------------------
	assign irq_set = {apb_done && pslverr_r, SLEEP_I, WDT_TIMEOUT_I};

	// Sticky bits, write one to clear; a new event beats the clear
	always_ff @(posedge CORE_CLK_I)
	begin
		if (rst)
			irq_stat_r <= BDMS_IRQ_RST;
		else if (apb_wr && idx == BDMS_IRQ_STAT_IDX && !PADDR_I[11])
			irq_stat_r <= (irq_stat_r & ~PWDATA_I[2:0]) | irq_set;
		else
			irq_stat_r <= irq_stat_r | irq_set;
	end

	always_ff @(posedge CORE_CLK_I)
	begin
		if (rst)
			irq_mask_r <= BDMS_IRQ_RST;
		else if (apb_wr && idx == BDMS_IRQ_MASK_IDX && !PADDR_I[11])
			irq_mask_r <= PWDATA_I[2:0];
	end

	assign IRQ_O = |(irq_stat_r & irq_mask_r);

	// ----------------------------------------------------------------
	// Cycle clock output
	// ----------------------------------------------------------------
	// Oscillator is sampled by the core clock, so it must run well below
	// half the core rate; outside RC mode the output rests low
	always_ff @(posedge CORE_CLK_I)
	begin
		if (rst)
		begin
			osc_prev_r <= 1'b0;
			div_r <= '0;
		end
		else
		begin
			osc_prev_r <= OSC_IN_I;
			if (!RC_MODE_I)
				div_r <= '0;
			else if (OSC_IN_I && !osc_prev_r)
				div_r <= div_r + 1'b1;
		end
	end

	assign CYCLE_CLK_O = div_r[BDMS_DIV_W-1];

endmodule

// ### hdl/bdms_pkg.sv
// Constants, types and the register map of the banked data memory block.
// Assumes one 10 MHz core clock; nothing else.
package bdms_pkg;

	// ----------------------------------------------------------------
	// Data memory map (file addresses, bank 1 has bit 7 set)
	// ----------------------------------------------------------------
	localparam logic [7:0] BDMS_INDIRECT_DATA_PORT_OFS = 8'h00;
	localparam logic [7:0] BDMS_TIMER0_COUNT_OFS = 8'h01;
	localparam logic [7:0] BDMS_PROG_COUNTER_LOW_OFS = 8'h02;
	localparam logic [7:0] BDMS_ALU_RESET_FLAGS_OFS = 8'h03;
	localparam logic [7:0] BDMS_INDIRECT_POINTER_OFS = 8'h04;
	localparam logic [7:0] BDMS_PORT_A_PINS_OFS = 8'h05;
	localparam logic [7:0] BDMS_PORT_B_PINS_OFS = 8'h06;
	localparam logic [7:0] BDMS_PROG_COUNTER_HIGH_LATCH_OFS = 8'h0a;
	localparam logic [7:0] BDMS_INTERRUPT_CONTROL_OFS = 8'h0b;
	localparam logic [7:0] BDMS_PERIPHERAL_INT_FLAGS_OFS = 8'h0c;
	localparam logic [7:0] BDMS_COMPARATOR_CONTROL_OFS = 8'h1f;
	localparam logic [7:0] BDMS_CORE_OPTIONS_OFS = 8'h81;
	localparam logic [7:0] BDMS_PORT_A_DIRECTION_OFS = 8'h85;
	localparam logic [7:0] BDMS_PORT_B_DIRECTION_OFS = 8'h86;
	localparam logic [7:0] BDMS_PERIPHERAL_INT_ENABLES_OFS = 8'h8c;
	localparam logic [7:0] BDMS_POWER_CONTROL_OFS = 8'h8e;
	localparam logic [7:0] BDMS_VOLTAGE_REF_CONTROL_OFS = 8'h9f;
	localparam logic [7:0] BDMS_GPR0_FIRST = 8'h20;
	localparam logic [7:0] BDMS_GPR0_LAST = 8'h7f;
	localparam logic [7:0] BDMS_GPR1_FIRST = 8'ha0;
	localparam logic [7:0] BDMS_GPR1_LAST_DFLT = 8'hbf;
	localparam logic [7:0] BDMS_GPR1_NONE = 8'h9f;

	// ----------------------------------------------------------------
	// Status register fields and reset value
	// ----------------------------------------------------------------
	localparam int BDMS_ST_C = 0;
	localparam int BDMS_ST_DC = 1;
	localparam int BDMS_ST_Z = 2;
	localparam int BDMS_ST_SLEEP = 3;
	localparam int BDMS_ST_WDOG = 4;
	localparam int BDMS_ST_RP0 = 5;
	localparam logic [7:0] BDMS_STATUS_RST = 8'h18;

	// ----------------------------------------------------------------
	// Block-level registers above the file map (word indices)
	// ----------------------------------------------------------------
	localparam logic [8:0] BDMS_IRQ_STAT_IDX = 9'h100;
	localparam logic [8:0] BDMS_IRQ_MASK_IDX = 9'h101;
	localparam int BDMS_IRQ_W = 3;
	localparam int BDMS_IRQ_WDOG = 0;
	localparam int BDMS_IRQ_SLEEP = 1;
	localparam int BDMS_IRQ_BADADDR = 2;
	localparam logic [2:0] BDMS_IRQ_RST = 3'h0;

	// ----------------------------------------------------------------
	// Cycle clock divider
	// ----------------------------------------------------------------
	localparam int BDMS_OSC_DIV = 4;
	localparam int BDMS_DIV_W = $clog2(BDMS_OSC_DIV);

	// ----------------------------------------------------------------
	// Core operation request
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		BDMS_OP_MOVE = 4'h0,
		BDMS_OP_ADD = 4'h1,
		BDMS_OP_SUB = 4'h2,
		BDMS_OP_AND = 4'h3,
		BDMS_OP_OR = 4'h4,
		BDMS_OP_XOR = 4'h5,
		BDMS_OP_CLR = 4'h6,
		BDMS_OP_SWAP = 4'h7,
		BDMS_OP_BCLR = 4'h8,
		BDMS_OP_BSET = 4'h9
	} bdms_op_t;

	typedef struct packed {
		bdms_op_t op;
		logic [6:0] addr;
		logic [7:0] acc;
		logic [2:0] bit_sel;
		logic dest_file;
	} bdms_alu_req_t;

endpackage

// ### sim/bdms_top_properties.sv
// Concurrent checks on the ports of the banked data memory block.
// Assumes one core clock; bound onto bdms_top at the foot of this file.
`timescale 1ns/1ps
module bdms_top_properties
	import bdms_pkg::*;
(
	input wire logic CORE_CLK_I,
	input wire logic SYS_RST_I,
	input wire logic MCLR_N_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [31:0] PRDATA_O,
	input wire logic PREADY_O,
	input wire logic PSLVERR_O,
	input wire logic ALU_VALID_I,
	input wire bdms_alu_req_t ALU_REQ_I,
	input wire logic ALU_READY_O,
	input wire logic ALU_DONE_O,
	input wire logic [7:0] ALU_RESULT_O,
	input wire logic WDT_TIMEOUT_I,
	input wire logic SLEEP_I,
	input wire logic WDT_CLEAR_I,
	input wire logic RC_MODE_I,
	input wire logic CYCLE_CLK_O,
	input wire logic [7:0] STATUS_O
);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	// Either reset source stops every check except p_mclr, which only system reset stops
	default clocking cb @(posedge CORE_CLK_I);
	endclocking
	default disable iff (SYS_RST_I || !MCLR_N_I);
	// Core request accepted at this edge
	wire logic take = ALU_VALID_I && ALU_READY_O;
	// Any event or reset that may legally move the reset cause flags
	wire logic ev_any = WDT_TIMEOUT_I || SLEEP_I || WDT_CLEAR_I || SYS_RST_I || !MCLR_N_I;
	sequence s_take(bdms_op_t o);
		take && ALU_REQ_I.op == o;
	endsequence
	sequence s_quiet;
		!WDT_TIMEOUT_I && !SLEEP_I && !WDT_CLEAR_I;
	endsequence
	property p_one_wait;
		PSEL_I && $rose(PENABLE_I) |-> !PREADY_O ##1 PREADY_O;
	endproperty
	property p_err_zero;
		PSLVERR_O |-> PREADY_O && PRDATA_O == 32'h0000_0000;
	endproperty
	property p_hold_off;
		!ALU_READY_O |-> PSEL_I && PENABLE_I && PWRITE_I && PREADY_O;
	endproperty
	property p_add;
		s_take(BDMS_OP_ADD) |=> ALU_DONE_O && STATUS_O[0] == (ALU_RESULT_O < $past(ALU_REQ_I.acc))
			&& STATUS_O[1] == (ALU_RESULT_O[3:0] < $past(ALU_REQ_I.acc[3:0])) && STATUS_O[2] == (ALU_RESULT_O == 8'h00);
	endproperty
	property p_sub;
		s_take(BDMS_OP_SUB) |=> STATUS_O[0] == ({1'b0, ALU_RESULT_O} + {1'b0, $past(ALU_REQ_I.acc)} < 9'h100)
			&& STATUS_O[1] == ({1'b0, ALU_RESULT_O[3:0]} + {1'b0, $past(ALU_REQ_I.acc[3:0])} < 5'h10);
	endproperty
	property p_clr_st;
		s_take(BDMS_OP_CLR) ##0 s_quiet ##0 (ALU_REQ_I.addr == 7'h03 && ALU_REQ_I.dest_file)
			|=> STATUS_O[7:5] == 3'b000 && STATUS_O[2] && STATUS_O[4:3] == $past(STATUS_O[4:3])
			&& STATUS_O[1:0] == $past(STATUS_O[1:0]);
	endproperty
	// Reset cause flags move only on events or a reset
	property p_flag_lock;
		$changed(STATUS_O[4:3]) |-> $past(ev_any);
	endproperty
	property p_done;
		ALU_DONE_O |-> $past(take);
	endproperty
	property p_result_hold;
		!take |=> $stable(ALU_RESULT_O);
	endproperty
	property p_mclr;
		disable iff (SYS_RST_I) !MCLR_N_I |=> STATUS_O == BDMS_STATUS_RST && !ALU_DONE_O && !PREADY_O;
	endproperty
	property p_rc_off;
		!RC_MODE_I [*2] |-> !CYCLE_CLK_O;
	endproperty
	a_one_wait: assert property (p_one_wait) else $error("apb answer not after one wait state");
	a_err_zero: assert property (p_err_zero) else $error("error response carries data");
	a_hold_off: assert property (p_hold_off) else $error("core port stalled without apb write");
	a_add: assert property (p_add) else $error("add flags wrong");
	a_sub: assert property (p_sub) else $error("subtract borrow flags wrong");
	a_clr_st: assert property (p_clr_st) else $error("clear of status wrong");
	a_flag_lock: assert property (p_flag_lock) else $error("reset cause flag written");
	a_done: assert property (p_done) else $error("done without request");
	a_result_hold: assert property (p_result_hold) else $error("result moved without request");
	a_mclr: assert property (p_mclr) else $error("master clear did not reset");
	a_rc_off: assert property (p_rc_off) else $error("cycle clock runs outside rc mode");
endmodule

bind bdms_top bdms_top_properties u_props (.CORE_CLK_I, .SYS_RST_I, .MCLR_N_I, .PSEL_I, .PENABLE_I, .PWRITE_I,
	.PRDATA_O, .PREADY_O, .PSLVERR_O, .ALU_VALID_I, .ALU_REQ_I, .ALU_READY_O, .ALU_DONE_O, .ALU_RESULT_O,
	.WDT_TIMEOUT_I, .SLEEP_I, .WDT_CLEAR_I, .RC_MODE_I, .CYCLE_CLK_O, .STATUS_O);

// ### sim/bdms_top_test.sv
// Self-checking bench for the banked data memory block: map, flags, events, clocks.
// Assumes bdms_top with its checker bound; APB word index equals file address.
`timescale 1ns/1ps
module bdms_top_test
	import bdms_pkg::*;
;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic mclr_n = 1'b1;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic avalid = 1'b0;
	bdms_alu_req_t areq = '0;
	logic [2:0] ev = 3'h0;
	logic osc = 1'b0;
	logic rc = 1'b0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, ardy, adone, cclk, irq, er, ts;
	logic [7:0] ares, st, f, a, s;
	logic [15:0] e;
	logic [6:0] g;
	logic [2:0] b;
	bdms_op_t o;
	realtime t0;
	int failures = 0;
	int n_tests = 0;
	logic [7:0] sh[4] = '{8'h02, 8'h04, 8'h0a, 8'h0b};
	logic [7:0] un[5] = '{8'h07, 8'h0e, 8'h8d, 8'hc0, 8'hff};

	bdms_top uut
	(
		.CORE_CLK_I(clk), .SYS_RST_I(rst), .MCLR_N_I(mclr_n), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
		.PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(4'hf), .PRDATA_O(prdata), .PREADY_O(pready),
		.PSLVERR_O(pslverr), .ALU_VALID_I(avalid), .ALU_REQ_I(areq), .ALU_READY_O(ardy), .ALU_DONE_O(adone),
		.ALU_RESULT_O(ares), .WDT_TIMEOUT_I(ev[0]), .SLEEP_I(ev[1]), .WDT_CLEAR_I(ev[2]), .OSC_IN_I(osc),
		.RC_MODE_I(rc), .CYCLE_CLK_O(cclk), .STATUS_O(st), .IRQ_O(irq)
	);

	// ----------------------------------------
	// Clocks and watchdog
	// ----------------------------------------
	// Core clock, 100 ns period
	initial
	begin
		forever #50 clk = ~clk;
	end
	// Oscillator at a quarter of the core rate, inside the sampling limit
	initial
	begin
		forever
		begin
			repeat (2) @(posedge clk);
			osc <= ~osc;
		end
	end
	// A hang ends the run as a failure
	initial
	begin
		#2_000_000;
		failures++;
		end_sim();
	end

	// ----------------------------------------
	// Tasks and reference model
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			failures++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Full APB transfer; the request holds until the edge that samples pready high
	task automatic apb(input logic w, input logic [8:0] idx, input logic [7:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= {1'b0, idx, 2'b00};
		pwdata <= {24'h00_0000, d};
		@(posedge clk);
		pen <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
		// Let the write settle before anyone looks at its effect
		@(negedge clk);
	endtask
	task automatic rdc(input logic [8:0] idx, input logic [7:0] x);
		apb(1'b0, idx, 8'h00);
		chk(rd, {24'h0, x});
	endtask
	// One core operation into a file register; done is due one cycle after acceptance
	task automatic op(input logic [6:0] ad);
		@(posedge clk);
		avalid <= 1'b1;
		areq <= '{o, ad, a, b, 1'b1};
		do
			@(posedge clk);
		while (ardy !== 1'b1);
		avalid <= 1'b0;
		@(negedge clk);
		chk(adone, 1'b1);
	endtask
	task automatic pulse(input logic [2:0] k);
		@(posedge clk);
		ev <= k;
		@(posedge clk);
		ev <= 3'h0;
		@(negedge clk);
	endtask
	// Expected {status, result}; a flag-setting op into status keeps its written flags out
	function automatic logic [15:0] model(input logic tost);
		logic [8:0] r;
		logic [7:0] n;
		logic fl;
		fl = o inside {BDMS_OP_ADD, BDMS_OP_SUB, BDMS_OP_AND, BDMS_OP_OR, BDMS_OP_XOR, BDMS_OP_CLR};
		case (o)
			BDMS_OP_MOVE: r = {1'b0, a};
			BDMS_OP_ADD: r = {1'b0, f} + {1'b0, a};
			BDMS_OP_SUB: r = {1'b0, f} - {1'b0, a};
			BDMS_OP_AND: r = {1'b0, f & a};
			BDMS_OP_OR: r = {1'b0, f | a};
			BDMS_OP_XOR: r = {1'b0, f ^ a};
			BDMS_OP_CLR: r = 9'h000;
			BDMS_OP_SWAP: r = {1'b0, f[3:0], f[7:4]};
			BDMS_OP_BCLR: r = {1'b0, f & ~(8'h01 << b)};
			default: r = {1'b0, f | (8'h01 << b)};
		endcase
		n = tost ? {r[7:5], s[4:3], fl ? s[2:0] : r[2:0]} : s;
		if (fl)
			n[2] = (r[7:0] == 8'h00);
		if (o == BDMS_OP_ADD)
			n[1:0] = {({1'b0, f[3:0]} + {1'b0, a[3:0]}) > 5'h0f, r[8]};
		if (o == BDMS_OP_SUB)
			n[1:0] = {f[3:0] >= a[3:0], ~r[8]};
		return {n, r[7:0]};
	endfunction
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	// Reset, then map, status, core operations, events, master clear, cycle clock
	initial
	begin
		void'($urandom(32'h0647_c3b1));
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		chk(st, BDMS_STATUS_RST);
		chk(irq, 1'b0);
		$display("test reset done");
		for (int i = 0; i < 4; i++)
		begin
			f = 8'($urandom);
			apb(1'b1, {1'b0, sh[i] | 8'h80}, f);
			rdc({1'b0, sh[i]}, f);
		end
		for (int i = 0; i < 5; i++)
		begin
			apb(1'b1, {1'b0, un[i]}, 8'hff);
			rdc({1'b0, un[i]}, 8'h00);
		end
		f = 8'($urandom);
		apb(1'b1, 9'h004, 8'h2a);
		apb(1'b1, 9'h000, f);
		rdc(9'h02a, f);
		rdc(9'h080, f);
		apb(1'b1, 9'h003, 8'h07);
		rdc(9'h003, 8'h1f);
		apb(1'b1, 9'h003, 8'h00);
		$display("test map done");
		for (int i = 0; i < 50; i++)
		begin
			o = bdms_op_t'(i < 10 ? i : $urandom_range(9, 0));
			ts = (i == 4) || (i == 6) || ($urandom_range(3, 0) == 0);
			g = ts ? 7'h03 : 7'h20 + 7'($urandom_range(95, 0));
			a = 8'($urandom);
			b = 3'($urandom);
			f = 8'($urandom);
			apb(1'b0, 9'h003, 8'h00);
			s = rd[7:0];
			if (ts)
				f = s;
			else
				apb(1'b1, {2'b00, g}, f);
			e = model(ts);
			op(g);
			chk(ares, e[7:0]);
			chk(st, e[15:8]);
			if (ts)
				apb(1'b1, 9'h003, 8'h00);
			else
				rdc({2'b00, g}, e[7:0]);
		end
		$display("test core ops done");
		pulse(3'b001);
		pulse(3'b010);
		chk(st[4:3], 2'b00);
		apb(1'b0, 9'h102, 8'h00);
		chk(er, 1'b1);
		chk(rd, 32'h0000_0000);
		rdc(9'h100, 8'h07);
		chk(irq, 1'b0);
		apb(1'b1, 9'h101, 8'h05);
		chk(irq, 1'b1);
		apb(1'b1, 9'h100, 8'h05);
		chk(irq, 1'b0);
		rdc(9'h100, 8'h02);
		apb(1'b1, 9'h100, 8'h02);
		pulse(3'b100);
		chk(st[4:3], 2'b11);
		$display("test events done");
		apb(1'b1, 9'h003, 8'h07);
		@(posedge clk);
		mclr_n <= 1'b0;
		repeat (3) @(posedge clk);
		mclr_n <= 1'b1;
		@(negedge clk);
		chk(st, BDMS_STATUS_RST);
		@(posedge clk);
		rc <= 1'b1;
		@(posedge cclk);
		t0 = $realtime;
		@(posedge cclk);
		chk(32'($realtime - t0), 32'd1600);
		@(posedge clk);
		rc <= 1'b0;
		repeat (3) @(posedge clk);
		@(negedge clk);
		chk(cclk, 1'b0);
		$display("test clocks done");
		end_sim();
	end
endmodule
